// File: core/power_mode_pkg.sv
package power_mode_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 8;

  localparam logic [ADDR_W-1:0] CTRL_ADDR   = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;

  // half cycles of the old and the new clock added to a source switch
  localparam int OLD_HALF_CYCLES = 5;
  localparam int NEW_HALF_CYCLES = 5;
  localparam int SWITCH_CYCLES   = (OLD_HALF_CYCLES + 1) / 2 + (NEW_HALF_CYCLES + 1) / 2;
  localparam logic [CNT_W-1:0] SWITCH_COUNT = CNT_W'(SWITCH_CYCLES);

  typedef enum logic [1:0] {SRC_NONE, SRC_PRI, SRC_SEC, SRC_INT} src_t;

  typedef enum logic [2:0] {ST_ACTIVE, ST_SW_WAIT, ST_SW_DELAY, ST_SLEEP, ST_WAKE_WAIT} fsm_t;

  typedef struct packed {
    logic upper;
    logic lower;
  } clock_select_field_t;

  localparam clock_select_field_t SEL_SECONDARY = 2'h1;

  typedef struct packed {
    logic                idle_on_sleep_bit;
    logic [2:0]          internal_freq_select;
    logic                secondary_osc_enable;
    logic                reserved;
    clock_select_field_t clock_select_field;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = 8'h00;

  typedef struct packed {
    logic primary_stable_flag;
    logic internal_osc_stable_flag;
    logic secondary_clock_running_flag;
  } flags_t;

  localparam flags_t FLAGS_RESET = 3'h4;

  typedef struct packed {
    logic [1:0] zero;
    logic       sleeping;
    logic       idle;
    logic       switching;
    flags_t     flags;
  } status_t;

  typedef struct packed {
    logic pri;
    logic sec;
    logic fast;
  } osc_ready_t;

  typedef struct packed {
    logic two_speed;
    logic fail_safe;
    logic watchdog;
  } strap_t;

  typedef struct packed {
    logic primary;
    logic secondary;
    logic fast_internal_osc;
    logic slow_internal_osc;
  } osc_enable_t;

endpackage

// File: core/power_mode_clock_manager.sv
// How it works
// - select 01: run secondary, primary off, flags
// - defer secondary switch until enabled and ready
// - keep secondary clock until primary ready
// - back on primary: secondary flag clear, primary set
// - upper select bit alone picks internal run
// - leaving primary for internal stops primary oscillator
// - frequency select takes effect at once
// - internal to primary: keep internal, then flags
// - sleep without idle bit stops the oscillator
// - full sleep clears all source flags
// - watchdog and secondary oscillators survive sleep
// - wake waits for source, or runs internal
// - primary flag set once primary clocks device
// - wake leaves idle bit and select unchanged
// - sleep with idle bit gates CPU only
// - idle entry leaves source flags alone
// - idle exit by wake, then CPU start delay
// - watchdog timeout in idle or sleep wakes
// - primary idle keeps primary running and flagged
// - secondary idle switches and sets secondary flag
// - secondary idle without enable keeps old clock
// - switch lasts ready time plus five halves of each clock
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module power_mode_clock_manager #(
  parameter int CPU_START_CYCLES = 8
) (
  input  wire  logic                                  clock,
  input  wire  logic                                  rst,
  input  wire  logic [power_mode_pkg::ADDR_W-1:0]     addr,
  input  wire  logic [power_mode_pkg::DATA_W-1:0]     wdata,
  input  wire  logic                                  wr_stb,
  input  wire  logic                                  rd_stb,
  output logic       [power_mode_pkg::DATA_W-1:0]     rdata,
  input  wire  logic                                  sleep_exec,
  input  wire  logic                                  wake_irq,
  input  wire  logic                                  watchdog_timeout,
  input  wire  power_mode_pkg::osc_ready_t            osc_ready,
  input  wire  power_mode_pkg::strap_t                straps,
  output power_mode_pkg::osc_enable_t                 osc_enable,
  output power_mode_pkg::src_t                        clk_sel,
  output logic                                        cpu_clk_en,
  output logic                                        periph_clk_en,
  output logic       [2:0]                            internal_freq
);

  localparam logic [power_mode_pkg::CNT_W-1:0] CPU_COUNT = power_mode_pkg::CNT_W'(CPU_START_CYCLES);

  typedef struct packed {
    power_mode_pkg::osc_ready_t  rdy_meta;
    power_mode_pkg::osc_ready_t  rdy;
    power_mode_pkg::strap_t      strap_meta;
    power_mode_pkg::strap_t      strap;
    power_mode_pkg::ctrl_t       ctrl;
    power_mode_pkg::flags_t      flags;
    power_mode_pkg::fsm_t        fsm;
    power_mode_pkg::src_t        cur;
    power_mode_pkg::src_t        pend;
    logic [power_mode_pkg::CNT_W-1:0] cnt;
    logic [power_mode_pkg::CNT_W-1:0] cpu_cnt;
    logic                        idle;
    power_mode_pkg::src_t        clk_sel;
    logic                        cpu_clk_en;
    logic                        periph_clk_en;
    power_mode_pkg::osc_enable_t osc;
    logic [power_mode_pkg::DATA_W-1:0] rdata;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // upper bit wins, lower bit ignored then
  function automatic power_mode_pkg::src_t sel_to_src(input power_mode_pkg::clock_select_field_t sel);
    if (sel.upper) begin
      return power_mode_pkg::SRC_INT;
    end else if (sel.lower) begin
      return power_mode_pkg::SRC_SEC;
    end
    return power_mode_pkg::SRC_PRI;
  endfunction

  function automatic logic src_ready(input power_mode_pkg::src_t src, input power_mode_pkg::osc_ready_t rdy);
    case (src)
      power_mode_pkg::SRC_PRI: return rdy.pri;
      power_mode_pkg::SRC_SEC: return rdy.sec;
      power_mode_pkg::SRC_INT: return rdy.fast;
      default:                 return 1'b0;
    endcase
  endfunction

  function automatic power_mode_pkg::flags_t flags_for(input power_mode_pkg::src_t src, input logic fast_rdy);
    power_mode_pkg::flags_t f;
    f.primary_stable_flag          = (src == power_mode_pkg::SRC_PRI);
    f.secondary_clock_running_flag = (src == power_mode_pkg::SRC_SEC);
    f.internal_osc_stable_flag     = (src == power_mode_pkg::SRC_INT) && fast_rdy;
    return f;
  endfunction

  power_mode_pkg::src_t    tgt;
  logic                    wake;
  logic                    sec_blocked;
  power_mode_pkg::status_t status;

  assign tgt         = sel_to_src(s_r.ctrl.clock_select_field);
  assign wake        = wake_irq | watchdog_timeout;
  assign sec_blocked = (tgt == power_mode_pkg::SRC_SEC) && !s_r.ctrl.secondary_osc_enable;

  always_comb begin
    status           = '0;
    status.sleeping  = (s_r.fsm == power_mode_pkg::ST_SLEEP) || (s_r.fsm == power_mode_pkg::ST_WAKE_WAIT);
    status.idle      = s_r.idle;
    status.switching = (s_r.fsm == power_mode_pkg::ST_SW_WAIT) || (s_r.fsm == power_mode_pkg::ST_SW_DELAY);
    status.flags     = s_r.flags;
  end

  always_comb begin
    s_nxt = s_r;
    // readiness and straps come from other clock domains
    s_nxt.rdy_meta   = osc_ready;
    s_nxt.rdy        = s_r.rdy_meta;
    s_nxt.strap_meta = straps;
    s_nxt.strap      = s_r.strap_meta;

    // only software writes touch the control fields; wake never does
    if (wr_stb && addr == power_mode_pkg::CTRL_ADDR) begin
      s_nxt.ctrl          = power_mode_pkg::ctrl_t'(wdata);
      s_nxt.ctrl.reserved = 1'b0;
    end

    s_nxt.rdata = '0;
    if (rd_stb) begin
      if (addr == power_mode_pkg::CTRL_ADDR) begin
        s_nxt.rdata = s_r.ctrl;
      end else if (addr == power_mode_pkg::STATUS_ADDR) begin
        s_nxt.rdata = status;
      end
    end

    if (s_r.cpu_cnt != '0) begin
      s_nxt.cpu_cnt = s_r.cpu_cnt - 1'b1;
    end

    // idle exits on wake in any clocked state, switch may still run
    if (s_r.idle && wake) begin
      s_nxt.idle    = 1'b0;
      s_nxt.cpu_cnt = CPU_COUNT;
    end

    case (s_r.fsm)
      power_mode_pkg::ST_ACTIVE: begin
        if (s_r.cur == power_mode_pkg::SRC_INT && !s_r.idle) begin
          s_nxt.flags.internal_osc_stable_flag = s_r.rdy.fast;
        end
        if (sleep_exec && !s_r.idle && s_r.cpu_cnt == '0) begin
          if (s_r.ctrl.idle_on_sleep_bit) begin
            s_nxt.idle = 1'b1;
          end else begin
            s_nxt.fsm   = power_mode_pkg::ST_SLEEP;
            s_nxt.cur   = power_mode_pkg::SRC_NONE;
            s_nxt.flags = '0;
          end
        end else if (tgt != s_r.cur && !sec_blocked) begin
          // a blocked secondary request keeps the old source, idle or not
          s_nxt.fsm  = power_mode_pkg::ST_SW_WAIT;
          s_nxt.pend = tgt;
        end
      end
      power_mode_pkg::ST_SW_WAIT: begin
        // old source keeps clocking until the new one is ready
        if (tgt != s_r.pend || sec_blocked) begin
          s_nxt.fsm = power_mode_pkg::ST_ACTIVE;
        end else if (src_ready(s_r.pend, s_r.rdy)) begin
          s_nxt.fsm = power_mode_pkg::ST_SW_DELAY;
          s_nxt.cnt = power_mode_pkg::SWITCH_COUNT;
        end
      end
      power_mode_pkg::ST_SW_DELAY: begin
        if (s_r.cnt <= 1) begin
          s_nxt.fsm   = power_mode_pkg::ST_ACTIVE;
          s_nxt.cur   = s_r.pend;
          s_nxt.flags = flags_for(s_r.pend, s_r.rdy.fast);
          s_nxt.cnt   = '0;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      power_mode_pkg::ST_SLEEP: begin
        if (wake) begin
          s_nxt.fsm  = power_mode_pkg::ST_WAKE_WAIT;
          s_nxt.pend = sec_blocked ? power_mode_pkg::SRC_PRI : tgt;
        end
      end
      power_mode_pkg::ST_WAKE_WAIT: begin
        if (src_ready(s_r.pend, s_r.rdy)) begin
          s_nxt.fsm     = power_mode_pkg::ST_ACTIVE;
          s_nxt.cur     = s_r.pend;
          s_nxt.flags   = flags_for(s_r.pend, s_r.rdy.fast);
          s_nxt.cpu_cnt = CPU_COUNT;
        end
      end
      default: begin
        s_nxt.fsm = power_mode_pkg::ST_ACTIVE;
      end
    endcase

    // clock tree from the next state, so outputs leave flip-flops directly
    case (s_nxt.fsm)
      power_mode_pkg::ST_SLEEP: s_nxt.clk_sel = power_mode_pkg::SRC_NONE;
      power_mode_pkg::ST_WAKE_WAIT: begin
        s_nxt.clk_sel = (s_r.strap.two_speed || s_r.strap.fail_safe) ?
                        power_mode_pkg::SRC_INT : power_mode_pkg::SRC_NONE;
      end
      default: s_nxt.clk_sel = s_nxt.cur;
    endcase
    s_nxt.periph_clk_en = (s_nxt.clk_sel != power_mode_pkg::SRC_NONE);
    s_nxt.cpu_clk_en    = s_nxt.periph_clk_en && !s_nxt.idle && s_nxt.cpu_cnt == '0 &&
                          s_nxt.fsm != power_mode_pkg::ST_WAKE_WAIT;

    // oscillator enables; a pending source starts while the old one runs
    s_nxt.osc.primary = (s_nxt.cur == power_mode_pkg::SRC_PRI) ||
                        (s_nxt.fsm != power_mode_pkg::ST_ACTIVE && s_nxt.fsm != power_mode_pkg::ST_SLEEP &&
                         s_nxt.pend == power_mode_pkg::SRC_PRI);
    s_nxt.osc.secondary = s_nxt.ctrl.secondary_osc_enable || (s_nxt.cur == power_mode_pkg::SRC_SEC);
    s_nxt.osc.fast_internal_osc = (s_nxt.clk_sel == power_mode_pkg::SRC_INT) ||
                                  (s_nxt.fsm != power_mode_pkg::ST_ACTIVE &&
                                   s_nxt.fsm != power_mode_pkg::ST_SLEEP &&
                                   s_nxt.pend == power_mode_pkg::SRC_INT);
    // straps read from the second synchroniser stage only, never the first
    s_nxt.osc.slow_internal_osc = s_r.strap.watchdog || (s_nxt.cur == power_mode_pkg::SRC_INT);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r         <= '0;
      s_r.ctrl    <= power_mode_pkg::CTRL_RESET;
      s_r.flags   <= power_mode_pkg::FLAGS_RESET;
      s_r.fsm     <= power_mode_pkg::ST_ACTIVE;
      s_r.cur     <= power_mode_pkg::SRC_PRI;
      s_r.pend    <= power_mode_pkg::SRC_PRI;
      s_r.clk_sel <= power_mode_pkg::SRC_PRI;
      s_r.osc     <= 4'h8;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata         = s_r.rdata;
  assign osc_enable    = s_r.osc;
  assign clk_sel       = s_r.clk_sel;
  assign cpu_clk_en    = s_r.cpu_clk_en;
  assign periph_clk_en = s_r.periph_clk_en;
  assign internal_freq = s_r.ctrl.internal_freq_select;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_sleep_flags_clear: assert property (
    (s_r.fsm == power_mode_pkg::ST_SLEEP) |-> (s_r.flags == '0 && !s_r.periph_clk_en))
    else $error("source flags or clocks alive in full sleep");

  chk_sec_defer: assert property (
    (s_r.fsm == power_mode_pkg::ST_ACTIVE && sec_blocked && !sleep_exec) |=> (s_r.fsm != power_mode_pkg::ST_SW_WAIT))
    else $error("secondary switch started while disabled");

  chk_switch_length: assert property (
    $rose(s_r.fsm == power_mode_pkg::ST_SW_DELAY) |-> ##6 (s_r.fsm == power_mode_pkg::ST_ACTIVE))
    else $error("switch delay has wrong length");

  chk_old_clock_kept: assert property (
    (s_r.fsm == power_mode_pkg::ST_SW_WAIT || s_r.fsm == power_mode_pkg::ST_SW_DELAY) |-> (s_r.clk_sel == s_r.cur))
    else $error("clock moved before switch completed");

  chk_idle_cpu_gated: assert property (
    s_r.idle |-> (!s_r.cpu_clk_en && s_r.periph_clk_en == (s_r.clk_sel != power_mode_pkg::SRC_NONE)))
    else $error("cpu clocked in idle");

  chk_idle_flags_kept: assert property (
    (s_r.fsm == power_mode_pkg::ST_ACTIVE && sleep_exec && s_r.ctrl.idle_on_sleep_bit && !s_r.idle &&
     s_r.cpu_cnt == '0) |=> (s_r.idle && s_r.flags == $past(s_r.flags)))
    else $error("idle entry altered source flags");

  chk_cpu_start_delay: assert property (
    $fell(s_r.idle) |-> (s_r.cpu_cnt == CPU_COUNT && !s_r.cpu_clk_en))
    else $error("cpu resumed without start delay");

  chk_wake_keeps_ctrl: assert property (
    (wake && !wr_stb) |=> (s_r.ctrl == $past(s_r.ctrl)))
    else $error("wake altered control fields");

  chk_sleep_osc_off: assert property (
    (s_r.fsm == power_mode_pkg::ST_SLEEP) |-> (!s_r.osc.primary && !s_r.osc.fast_internal_osc))
    else $error("oscillator left running in full sleep");

  chk_secondary_run_mode_flags: assert property (
    (s_r.cur == power_mode_pkg::SRC_SEC && s_r.fsm == power_mode_pkg::ST_ACTIVE) |->
    (s_r.flags.secondary_clock_running_flag && !s_r.flags.primary_stable_flag && !s_r.osc.primary))
    else $error("secondary run state flags wrong");

  chk_freq_immediate: assert property (
    (wr_stb && addr == power_mode_pkg::CTRL_ADDR) |=> (internal_freq == $past(wdata[6:4])))
    else $error("frequency select not applied at once");

  // each source flag only while its own clock drives the system
  chk_pri_flag_source: assert property (
    s_r.flags.primary_stable_flag |-> (s_r.clk_sel == power_mode_pkg::SRC_PRI))
    else $error("primary flag set while primary not selected");

  chk_sec_flag_source: assert property (
    s_r.flags.secondary_clock_running_flag |-> (s_r.clk_sel == power_mode_pkg::SRC_SEC))
    else $error("secondary flag set while secondary not selected");

  chk_int_flag_source: assert property (
    s_r.flags.internal_osc_stable_flag |-> (s_r.clk_sel == power_mode_pkg::SRC_INT))
    else $error("internal flag set while internal not selected");

  chk_int_run_pri_off: assert property (
    (s_r.fsm == power_mode_pkg::ST_ACTIVE && s_r.cur == power_mode_pkg::SRC_INT) |->
    (!s_r.osc.primary && !s_r.flags.primary_stable_flag))
    else $error("primary left on in internal run");

  chk_sec_osc_enabled: assert property (
    s_r.ctrl.secondary_osc_enable |-> s_r.osc.secondary)
    else $error("secondary oscillator stopped while enabled");

  // enable is registered from the synchronised strap, one cycle behind it
  chk_slow_osc_kept: assert property (
    s_r.strap.watchdog |=> s_r.osc.slow_internal_osc)
    else $error("slow internal oscillator stopped with watchdog selected");

  chk_primary_idle_mode_kept: assert property (
    (s_r.idle && s_r.fsm == power_mode_pkg::ST_ACTIVE && s_r.cur == power_mode_pkg::SRC_PRI) |->
    (s_r.osc.primary && s_r.clk_sel == power_mode_pkg::SRC_PRI && s_r.periph_clk_en))
    else $error("primary idle lost its clock");

  chk_wake_wait_gated: assert property (
    (s_r.fsm == power_mode_pkg::ST_WAKE_WAIT) |->
    (!s_r.cpu_clk_en && s_r.flags == '0 && s_r.clk_sel != power_mode_pkg::SRC_PRI &&
     s_r.clk_sel != power_mode_pkg::SRC_SEC))
    else $error("clock supplied before the selected source was ready");

  chk_sleep_resume_delay: assert property (
    $fell(s_r.fsm == power_mode_pkg::ST_WAKE_WAIT) |->
    (s_r.fsm == power_mode_pkg::ST_ACTIVE && s_r.cpu_cnt == CPU_COUNT && !s_r.cpu_clk_en))
    else $error("cpu resumed after sleep without start delay");

  chk_back_to_primary: assert property (
    ($past(s_r.cur) == power_mode_pkg::SRC_SEC && s_r.cur == power_mode_pkg::SRC_PRI) |->
    (s_r.flags.primary_stable_flag && !s_r.flags.secondary_clock_running_flag))
    else $error("flags wrong after return to primary");

  chk_pri_wait_ready: assert property (
    (s_r.fsm == power_mode_pkg::ST_SW_WAIT && s_r.pend == power_mode_pkg::SRC_PRI && !s_r.rdy.pri) |=>
    (s_r.fsm != power_mode_pkg::ST_SW_DELAY))
    else $error("switch to primary started before it was ready");

  chk_int_select: assert property (
    (s_r.fsm == power_mode_pkg::ST_ACTIVE && s_r.ctrl.clock_select_field.upper &&
     s_r.cur != power_mode_pkg::SRC_INT && !sleep_exec) |=>
    (s_r.fsm == power_mode_pkg::ST_SW_WAIT && s_r.pend == power_mode_pkg::SRC_INT))
    else $error("upper select bit did not start internal run");

  chk_sleep_entry: assert property (
    (s_r.fsm == power_mode_pkg::ST_ACTIVE && sleep_exec && !s_r.ctrl.idle_on_sleep_bit && !s_r.idle &&
     s_r.cpu_cnt == '0) |=> (s_r.fsm == power_mode_pkg::ST_SLEEP && s_r.clk_sel == power_mode_pkg::SRC_NONE))
    else $error("sleep without idle bit did not stop the clocks");

  chk_blocked_idle: assert property (
    (s_r.fsm == power_mode_pkg::ST_ACTIVE && sleep_exec && s_r.ctrl.idle_on_sleep_bit && sec_blocked &&
     !s_r.idle && s_r.cpu_cnt == '0) |=> (s_r.idle && s_r.clk_sel == $past(s_r.clk_sel)))
    else $error("disabled secondary idle changed the system clock");

  cov_idle_entry:  cover property (s_r.fsm == power_mode_pkg::ST_ACTIVE && $rose(s_r.idle));
  cov_sleep_wake:  cover property ($rose(s_r.fsm == power_mode_pkg::ST_WAKE_WAIT));
  cov_to_sec:      cover property ($rose(s_r.cur == power_mode_pkg::SRC_SEC));
  cov_int_to_pri:  cover property ($past(s_r.cur) == power_mode_pkg::SRC_INT && s_r.cur == power_mode_pkg::SRC_PRI);
  cov_two_speed:   cover property ($rose(s_r.fsm == power_mode_pkg::ST_WAKE_WAIT && s_r.clk_sel == power_mode_pkg::SRC_INT));

endmodule

`default_nettype wire

// File: tb/osc_model.sv
`timescale 1ns/1ns
`default_nettype none

module osc_model #(
  parameter int DELAY = 12
) (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire power_mode_pkg::osc_enable_t osc_enable,
  output var  power_mode_pkg::osc_ready_t  osc_ready
);
  int         cnt [3];
  logic [2:0] en;

  assign en = {osc_enable.primary, osc_enable.secondary, osc_enable.fast_internal_osc};

  // ready drops at once when stopped, so a stale ready is never seen
  always @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      if (rst || !en[i]) begin
        cnt[i] <= 0;
      end else if (cnt[i] < DELAY) begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end

  always_comb begin
    osc_ready.pri  = en[2] && cnt[2] == DELAY;
    osc_ready.sec  = en[1] && cnt[1] == DELAY;
    osc_ready.fast = en[0] && cnt[0] == DELAY;
  end
endmodule

`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  localparam int         START = 4;
  localparam logic [7:0] CT    = power_mode_pkg::CTRL_ADDR;
  localparam logic [7:0] ST    = power_mode_pkg::STATUS_ADDR;
  localparam logic [7:0] NONE  = 8'(power_mode_pkg::SRC_NONE);
  localparam logic [7:0] PRI   = 8'(power_mode_pkg::SRC_PRI);
  localparam logic [7:0] SEC   = 8'(power_mode_pkg::SRC_SEC);
  localparam logic [7:0] INT   = 8'(power_mode_pkg::SRC_INT);

  logic                        clock = 1'b0;
  logic                        rst = 1'b1;
  logic [7:0]                  addr = 8'h00;
  logic [7:0]                  wdata = 8'h00;
  logic [7:0]                  rdata;
  logic                        wr_stb = 1'b0;
  logic                        rd_stb = 1'b0;
  logic                        sleep_exec = 1'b0;
  logic                        wake_irq = 1'b0;
  logic                        watchdog_timeout = 1'b0;
  power_mode_pkg::osc_ready_t  osc_ready;
  power_mode_pkg::strap_t      straps = 3'h1;
  power_mode_pkg::osc_enable_t osc_enable;
  power_mode_pkg::src_t        clk_sel;
  logic                        cpu_clk_en;
  logic                        periph_clk_en;
  logic [2:0]                  internal_freq;
  int                          err_count = 0;
  int                          checked = 0;

  always #4 clock = ~clock;

  power_mode_clock_manager #(.CPU_START_CYCLES(START)) power_mode_clock_manager_i (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .sleep_exec(sleep_exec), .wake_irq(wake_irq), .watchdog_timeout(watchdog_timeout),
    .osc_ready(osc_ready), .straps(straps), .osc_enable(osc_enable), .clk_sel(clk_sel),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .internal_freq(internal_freq));

  osc_model osc_model_i (.clock(clock), .rst(rst), .osc_enable(osc_enable), .osc_ready(osc_ready));

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    tick(1);
    wr_stb <= 1'b0;
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
    addr <= a;
    rd_stb <= 1'b1;
    tick(1);
    rd_stb <= 1'b0;
    tick(1);
    chk_pin(rdata, exp);
  endtask

  task automatic wait_sel(input logic [7:0] s);
    int n;
    n = 0;
    while (8'(clk_sel) !== s && n < 300) begin
      tick(1);
      n++;
    end
    chk_pin(8'(clk_sel), s);
  endtask

  task automatic sleep_pulse();
    sleep_exec <= 1'b1;
    tick(1);
    sleep_exec <= 1'b0;
    tick(2);
  endtask

  // cpu must stay gated for the start delay, then come back in bounded time
  task automatic wake(input logic wd, input logic [7:0] mid);
    int n;
    n = 0;
    if (wd) watchdog_timeout <= 1'b1;
    else wake_irq <= 1'b1;
    tick(1);
    watchdog_timeout <= 1'b0;
    wake_irq <= 1'b0;
    repeat (START) begin
      tick(1);
      chk_pin({7'h0, cpu_clk_en}, 8'h00);
    end
    chk_pin(8'(clk_sel), mid);
    while (cpu_clk_en !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    chk_pin({7'h0, cpu_clk_en}, 8'h01);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    tick(10);
    rst <= 1'b0;
    tick(3);
    chk_reg(CT, 8'h00);
    chk_reg(ST, 8'h04);
    chk_reg(8'h08, 8'h00);
    wr(CT, 8'h01);
    tick(40);
    chk_pin(8'(clk_sel), PRI);
    wr(CT, 8'h09);
    wait_sel(SEC);
    chk_reg(ST, 8'h01);
    chk_pin({7'h0, osc_enable.primary}, 8'h00);
    wr(CT, 8'h08);
    tick(5);
    chk_pin(8'(clk_sel), SEC);
    wait_sel(PRI);
    chk_reg(ST, 8'h04);
    chk_pin({7'h0, osc_enable.secondary}, 8'h01);
    wr(CT, 8'h13);
    wait_sel(INT);
    chk_pin({7'h0, osc_enable.primary}, 8'h00);
    tick(4);
    chk_reg(ST, 8'h02);
    wr(CT, 8'h52);
    tick(1);
    chk_pin({5'h0, internal_freq}, 8'h05);
    chk_pin(8'(clk_sel), INT);
    wr(CT, 8'h00);
    tick(5);
    chk_pin(8'(clk_sel), INT);
    wait_sel(PRI);
    chk_reg(ST, 8'h04);
    // idle bit first, then select, then sleep
    wr(CT, 8'h80);
    sleep_pulse();
    chk_pin({6'h0, cpu_clk_en, periph_clk_en}, 8'h01);
    chk_reg(ST, 8'h14);
    wake(1'b0, PRI);
    chk_reg(CT, 8'h80);
    chk_reg(ST, 8'h04);
    wr(CT, 8'h81);
    tick(20);
    sleep_pulse();
    chk_pin(8'(clk_sel), PRI);
    chk_reg(ST, 8'h14);
    wake(1'b1, PRI);
    wr(CT, 8'h89);
    wait_sel(SEC);
    sleep_pulse();
    chk_reg(ST, 8'h11);
    wake(1'b0, SEC);
    chk_reg(CT, 8'h89);
    wr(CT, 8'h08);
    wait_sel(PRI);
    sleep_pulse();
    chk_pin({6'h0, cpu_clk_en, periph_clk_en}, 8'h00);
    chk_pin(8'(osc_enable), 8'h05);
    chk_reg(ST, 8'h20);
    wake(1'b1, NONE);
    wait_sel(PRI);
    chk_reg(ST, 8'h04);
    straps <= 3'h5;
    tick(4);
    sleep_pulse();
    wake(1'b0, INT);
    wait_sel(PRI);
    chk_reg(ST, 8'h04);
    chk_reg(CT, 8'h08);
    // fail-safe monitor alone must also bridge the wake with the internal clock
    straps <= 3'h3;
    tick(4);
    sleep_pulse();
    wake(1'b1, INT);
    wait_sel(PRI);
    chk_reg(ST, 8'h04);
    wrap_up();
  end

  // whole sequence needs well under a few thousand cycles
  initial begin
    tick(20000);
    err_count++;
    wrap_up();
  end
endmodule

`default_nettype wire
